// [hdl/miller_pulse_timer.sv]
// module: miller modulation pulse length counter
module miller_pulse_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic carrier_tick_i,
  input wire logic pulse_start_i,
  input wire logic [7:0] width_i,
  // output
  output logic pulse_o
);

  logic [7:0] remaining;
  logic active;
  wire logic last_tick = carrier_tick_i && (remaining == 8'h00);

  // width latched at start, so a rewrite mid-pulse cannot shorten it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      remaining <= 8'h00;
      active <= 1'b0;
    end
    else if (pulse_start_i && !active)
    begin
      remaining <= width_i;
      active <= 1'b1;
    end
    else if (active && last_tick)
    begin
      active <= 1'b0;
    end
    else if (active && carrier_tick_i)
    begin
      remaining <= remaining - 8'h01;
    end
  end

  assign pulse_o = active;

endmodule : miller_pulse_timer

// [hdl/rf_driver_gain_config_regs.sv]
// module: rf analogue front end configuration register bank
// Behaviour
// - pulse width register 24h gives Miller pulse of value plus one carrier periods.
// - gain field bits 6..4 maps codes to 18,23,18,23,33,38,43,48 dB.
// - upper nibble 27h is idle n-driver conductance, used only with a driver on.
// - lower nibble 27h is modulation n-driver conductance, used only with a driver on.
// - bits 5..0 at 28h set idle p-driver conductance; bits 7..6 reserved.
// - soft power-down forces top bit of the applied p code, and of the n codes while a driver is on, high.
// - conductance codes are plain binary weighted values.
// - register 25h has no function and resets to 87h.
// - resets: 24h=26h, 26h=48h, 27h=88h, 28h=20h.
module rf_driver_gain_config_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port from host interface
  input wire rf_cfg_pkg::reg_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // analogue front end state
  input wire logic soft_power_down_i,
  input wire logic antenna_driver_one_on_i,
  input wire logic antenna_driver_two_on_i,
  input wire logic carrier_tick_i,
  input wire logic miller_pulse_start_i,
  // applied settings
  output logic miller_pulse_o,
  output logic [2:0] rx_gain_select_o,
  output logic [5:0] rx_gain_db_o,
  output rf_cfg_pkg::drive_cfg_s drive_cfg_o,
  output logic n_drive_enable_o
);

  // ***********************************************
  // storage
  // ***********************************************
  logic [7:0] modulation_width_cfg;
  logic [7:0] receiver_gain_cfg;
  logic [7:0] n_driver_conductance_cfg;
  logic [7:0] p_driver_idle_conductance_cfg;

  wire logic hit_width = req_i.addr == rf_cfg_pkg::MODULATION_WIDTH_CFG_ADDR;
  wire logic hit_rsvd = req_i.addr == rf_cfg_pkg::RESERVED_CFG_25_ADDR;
  wire logic hit_gain = req_i.addr == rf_cfg_pkg::RECEIVER_GAIN_CFG_ADDR;
  wire logic hit_n = req_i.addr == rf_cfg_pkg::N_DRIVER_CONDUCTANCE_CFG_ADDR;
  wire logic hit_p = req_i.addr == rf_cfg_pkg::P_DRIVER_IDLE_CONDUCTANCE_CFG_ADDR;

  // reserved bits merged from reset constant so they never change
  wire logic [7:0] gain_wr = (req_i.wdata & rf_cfg_pkg::RECEIVER_GAIN_RW_MASK)
    | (rf_cfg_pkg::RECEIVER_GAIN_RESET & ~rf_cfg_pkg::RECEIVER_GAIN_RW_MASK);
  wire logic [7:0] p_wr = (req_i.wdata & rf_cfg_pkg::P_DRIVER_RW_MASK)
    | (rf_cfg_pkg::P_DRIVER_RESET & ~rf_cfg_pkg::P_DRIVER_RW_MASK);

  // ***********************************************
  // write path
  // ***********************************************
  // no strobe for 25h: writes there fall on the floor
  wire logic wr_width = req_i.wr && hit_width;
  wire logic wr_gain = req_i.wr && hit_gain;
  wire logic wr_n = req_i.wr && hit_n;
  wire logic wr_p = req_i.wr && hit_p;
  wire logic [7:0] next_width = wr_width ? req_i.wdata : modulation_width_cfg;
  wire logic [7:0] next_gain = wr_gain ? gain_wr : receiver_gain_cfg;
  wire logic [7:0] next_n = wr_n ? req_i.wdata : n_driver_conductance_cfg;
  wire logic [7:0] next_p = wr_p ? p_wr : p_driver_idle_conductance_cfg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      modulation_width_cfg <= rf_cfg_pkg::MODULATION_WIDTH_RESET;
    end
    else
    begin
      modulation_width_cfg <= next_width;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      receiver_gain_cfg <= rf_cfg_pkg::RECEIVER_GAIN_RESET;
    end
    else
    begin
      receiver_gain_cfg <= next_gain;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      n_driver_conductance_cfg <= rf_cfg_pkg::N_DRIVER_RESET;
    end
    else
    begin
      n_driver_conductance_cfg <= next_n;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      p_driver_idle_conductance_cfg <= rf_cfg_pkg::P_DRIVER_RESET;
    end
    else
    begin
      p_driver_idle_conductance_cfg <= next_p;
    end
  end

  // ***********************************************
  // read path
  // ***********************************************
  // reserved register is a constant: writes there have no effect
  wire logic [7:0] read_mux =
    hit_width ? modulation_width_cfg :
    hit_rsvd ? rf_cfg_pkg::RESERVED_CFG_25_RESET :
    hit_gain ? receiver_gain_cfg :
    hit_n ? n_driver_conductance_cfg :
    hit_p ? p_driver_idle_conductance_cfg : 8'h00;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rdata_o <= req_i.rd ? read_mux : rdata_o;
      rvalid_o <= req_i.rd;
    end
  end

  // ***********************************************
  // receiver gain
  // ***********************************************
  wire logic [2:0] gain_code =
    receiver_gain_cfg[rf_cfg_pkg::RX_GAIN_MSB:rf_cfg_pkg::RX_GAIN_LSB];
  logic [5:0] next_gain_db;

  always_comb
  begin
    unique case (gain_code)
      3'h0, 3'h2: next_gain_db = rf_cfg_pkg::GAIN_18_DB;
      3'h1, 3'h3: next_gain_db = rf_cfg_pkg::GAIN_23_DB;
      3'h4: next_gain_db = rf_cfg_pkg::GAIN_33_DB;
      3'h5: next_gain_db = rf_cfg_pkg::GAIN_38_DB;
      3'h6: next_gain_db = rf_cfg_pkg::GAIN_43_DB;
      3'h7: next_gain_db = rf_cfg_pkg::GAIN_48_DB;
    endcase
  end

  // ***********************************************
  // driver conductance
  // ***********************************************
  // power-down pin is asynchronous to us, so two flops first
  logic pd_meta;
  logic pd_sync;
  wire logic [3:0] n_idle_raw =
    n_driver_conductance_cfg[rf_cfg_pkg::N_IDLE_MSB:rf_cfg_pkg::N_IDLE_LSB];
  wire logic [3:0] n_mod_raw =
    n_driver_conductance_cfg[rf_cfg_pkg::N_MOD_MSB:rf_cfg_pkg::N_MOD_LSB];
  wire logic [5:0] p_idle_raw =
    p_driver_idle_conductance_cfg[rf_cfg_pkg::P_IDLE_MSB:rf_cfg_pkg::P_IDLE_LSB];
  // codes pass through unscaled: analogue side weights bits binary
  wire logic [3:0] n_idle_applied = {n_idle_raw[3] | pd_sync, n_idle_raw[2:0]};
  wire logic [3:0] n_mod_applied = {n_mod_raw[3] | pd_sync, n_mod_raw[2:0]};
  wire logic [5:0] p_idle_applied = {p_idle_raw[5] | pd_sync, p_idle_raw[4:0]};
  // n codes only steer while a driver is on; otherwise zero conductance
  wire logic driver_on = antenna_driver_one_on_i | antenna_driver_two_on_i;

  // only pd_sync is read downstream; pd_meta may be metastable
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
    end
    else
    begin
      pd_meta <= soft_power_down_i;
      pd_sync <= pd_meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_gain_select_o <= 3'h0;
      rx_gain_db_o <= 6'h00;
    end
    else
    begin
      rx_gain_select_o <= gain_code;
      rx_gain_db_o <= next_gain_db;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drive_cfg_o <= '0;
      n_drive_enable_o <= 1'b0;
    end
    else
    begin
      drive_cfg_o.n_idle <= driver_on ? n_idle_applied : 4'h0;
      drive_cfg_o.n_mod <= driver_on ? n_mod_applied : 4'h0;
      drive_cfg_o.p_idle <= p_idle_applied;
      n_drive_enable_o <= driver_on;
    end
  end

  // ***********************************************
  // miller pulse
  // ***********************************************
  // no clamp to half a bit period: that limit is the host's to
  miller_pulse_timer u_pulse (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .carrier_tick_i(carrier_tick_i),
    .pulse_start_i(miller_pulse_start_i),
    .width_i(modulation_width_cfg),
    .pulse_o(miller_pulse_o)
  );

endmodule : rf_driver_gain_config_regs

// [include/rf_cfg_pkg.sv]
// package: register map, field layout, reset values and carriers for the rf driver config bank
package rf_cfg_pkg;

  // ***********************************************
  // register offsets
  // ***********************************************
  localparam logic [5:0] MODULATION_WIDTH_CFG_ADDR = 6'h24;
  localparam logic [5:0] RESERVED_CFG_25_ADDR = 6'h25;
  localparam logic [5:0] RECEIVER_GAIN_CFG_ADDR = 6'h26;
  localparam logic [5:0] N_DRIVER_CONDUCTANCE_CFG_ADDR = 6'h27;
  localparam logic [5:0] P_DRIVER_IDLE_CONDUCTANCE_CFG_ADDR = 6'h28;

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] MODULATION_WIDTH_RESET = 8'h26;
  localparam logic [7:0] RESERVED_CFG_25_RESET = 8'h87;
  localparam logic [7:0] RECEIVER_GAIN_RESET = 8'h48;
  localparam logic [7:0] N_DRIVER_RESET = 8'h88;
  localparam logic [7:0] P_DRIVER_RESET = 8'h20;

  // ***********************************************
  // field layout
  // ***********************************************
  localparam int RX_GAIN_LSB = 4;
  localparam int RX_GAIN_MSB = 6;
  localparam logic [7:0] RECEIVER_GAIN_RW_MASK = 8'h70;
  localparam int N_IDLE_LSB = 4;
  localparam int N_IDLE_MSB = 7;
  localparam int N_MOD_LSB = 0;
  localparam int N_MOD_MSB = 3;
  localparam int P_IDLE_LSB = 0;
  localparam int P_IDLE_MSB = 5;
  localparam logic [7:0] P_DRIVER_RW_MASK = 8'h3F;

  // ***********************************************
  // gain codes in dB
  // ***********************************************
  localparam logic [5:0] GAIN_18_DB = 6'h12;
  localparam logic [5:0] GAIN_23_DB = 6'h17;
  localparam logic [5:0] GAIN_33_DB = 6'h21;
  localparam logic [5:0] GAIN_38_DB = 6'h26;
  localparam logic [5:0] GAIN_43_DB = 6'h2B;
  localparam logic [5:0] GAIN_48_DB = 6'h30;

  // ***********************************************
  // carriers
  // ***********************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [3:0] n_idle;
    logic [3:0] n_mod;
    logic [5:0] p_idle;
  } drive_cfg_s;

endpackage : rf_cfg_pkg

// [tb/rf_driver_gain_config_regs_asserts.sv]
// port checks for the config bank
module rf_driver_gain_config_regs_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire rf_cfg_pkg::reg_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic soft_power_down_i,
  input wire logic carrier_tick_i,
  input wire logic miller_pulse_start_i,
  input wire logic miller_pulse_o,
  input wire logic [2:0] rx_gain_select_o,
  input wire logic [5:0] rx_gain_db_o,
  input wire rf_cfg_pkg::drive_cfg_s drive_cfg_o,
  input wire logic n_drive_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_gets_valid: assert property (req_i.rd |=> rvalid_o)
    else $error("read without valid");
  a_valid_needs_read: assert property (rvalid_o |-> $past(req_i.rd))
    else $error("valid without read");
  a_rdata_held: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("read data moved");
  a_gain_db_map: assert property ($past(rst_n_i) |->
    rx_gain_db_o == (rx_gain_select_o[2] ?
    6'h21 + 6'(rx_gain_select_o[1:0]) * 6'h05 : (rx_gain_select_o[0] ? 6'h17 : 6'h12)))
    else $error("gain in dB wrong");
  a_codes_off_idle: assert property (!n_drive_enable_o |->
    drive_cfg_o.n_idle == 4'h0 && drive_cfg_o.n_mod == 4'h0)
    else $error("n codes applied with drivers off");
  a_pulse_starts: assert property (miller_pulse_start_i && !miller_pulse_o |=>
    miller_pulse_o)
    else $error("pulse did not start");
  a_pulse_holds: assert property (miller_pulse_o && !carrier_tick_i |=> miller_pulse_o)
    else $error("pulse ended without tick");
  a_power_down_msb: assert property (soft_power_down_i [*3] |=> drive_cfg_o.p_idle[5] &&
    (!n_drive_enable_o || (drive_cfg_o.n_idle[3] && drive_cfg_o.n_mod[3])))
    else $error("top code bit not forced");
endmodule : rf_driver_gain_config_regs_asserts

// [tb/rf_driver_gain_config_regs_tb.sv]
// self-checking bench for the config bank
module rf_driver_gain_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rf_cfg_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic pd = 1'b0;
  logic drv_one = 1'b0;
  logic drv_two = 1'b0;
  logic tick = 1'b0;
  logic start = 1'b0;
  logic pulse;
  logic [2:0] gain_sel;
  logic [5:0] gain_db;
  rf_cfg_pkg::drive_cfg_s drive;
  logic n_en;
  logic [7:0] q;
  int failures = 0;
  int n_checks = 0;
  int ticks = 0;
  int t0;
  logic [5:0] addr_t[5] = '{6'h24, 6'h25, 6'h26, 6'h27, 6'h28};
  logic [7:0] rst_t[5] = '{8'h26, 8'h87, 8'h48, 8'h88, 8'h20};
  logic [7:0] ones_t[5] = '{8'hFF, 8'h87, 8'h78, 8'hFF, 8'h3F};
  logic [5:0] db_t[8] = '{6'h12, 6'h17, 6'h12, 6'h17, 6'h21, 6'h26, 6'h2B, 6'h30};
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) tick <= ~tick;
  always @(posedge clk_i) if (pulse && tick) ticks <= ticks + 1;
  rf_driver_gain_config_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .soft_power_down_i(pd),
    .antenna_driver_one_on_i(drv_one), .antenna_driver_two_on_i(drv_two),
    .carrier_tick_i(tick), .miller_pulse_start_i(start), .miller_pulse_o(pulse),
    .rx_gain_select_o(gain_sel), .rx_gain_db_o(gain_db), .drive_cfg_o(drive),
    .n_drive_enable_o(n_en));
  rf_host_model u_host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, q);
    check(q, e);
  endtask : rd_chk
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(addr_t[i], rst_t[i]);
    rd_chk(6'h29, 8'h00);
    for (int i = 0; i < 5; i++) wr(addr_t[i], 8'hFF);
    for (int i = 0; i < 5; i++) rd_chk(addr_t[i], ones_t[i]);
    wr(6'h29, 8'hFF);
    rd_chk(6'h29, 8'h00);
    $display("registers test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(6'h26, {1'b1, 3'(i), 4'hF});
      repeat (2) @(posedge clk_i);
      check(8'(gain_sel), 8'(i));
      check(8'(gain_db), 8'(db_t[i]));
    end
    $display("gain test done");
    wr(6'h27, 8'h35);
    wr(6'h28, 8'h15);
    repeat (2) @(posedge clk_i);
    check({drive.n_idle, drive.n_mod}, 8'h00);
    check(8'(n_en), 8'h00);
    drv_two <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({drive.n_idle, drive.n_mod}, 8'h35);
    check(8'(n_en), 8'h01);
    check(8'(drive.p_idle), 8'h15);
    pd <= 1'b1;
    repeat (5) @(posedge clk_i);
    check({drive.n_idle, drive.n_mod}, 8'hBD);
    check(8'(drive.p_idle), 8'h35);
    pd <= 1'b0;
    drv_two <= 1'b0;
    drv_one <= 1'b1;
    repeat (5) @(posedge clk_i);
    check({drive.n_idle, drive.n_mod}, 8'h35);
    check(8'(n_en), 8'h01);
    $display("drive test done");
    wr(6'h24, 8'h02); // width kept far below half a bit period
    t0 = ticks;
    start <= 1'b1;
    @(posedge clk_i) start <= 1'b0;
    repeat (12) @(posedge clk_i);
    check(8'(ticks - t0), 8'h03);
    check(8'(pulse), 8'h00);
    $display("pulse test done");
    complete_run();
  end
  // run takes about 2.4 us, so this only fires on a hang
  initial
  begin
    #100us;
    failures++;
    complete_run();
  end
endmodule : rf_driver_gain_config_regs_tb
bind rf_driver_gain_config_regs rf_driver_gain_config_regs_asserts u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .soft_power_down_i(soft_power_down_i), .carrier_tick_i(carrier_tick_i),
  .miller_pulse_start_i(miller_pulse_start_i), .miller_pulse_o(miller_pulse_o),
  .rx_gain_select_o(rx_gain_select_o), .rx_gain_db_o(rx_gain_db_o),
  .drive_cfg_o(drive_cfg_o), .n_drive_enable_o(n_drive_enable_o));

// [tb/rf_host_model.sv]
// host processor model driving the register request port
module rf_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output rf_cfg_pkg::reg_req_s req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // idle bus shows inverted address and data, never a stale copy
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i) req_o <= {w, ~w, a, d};
    @(posedge clk_i) req_o <= {2'b00, ~a, ~d};
    if (!w)
    begin
      do @(posedge clk_i); while (rvalid_i !== 1'b1 && ++n < 4);
    end
    // a read that never gets valid hands back unknown, so its compare fails
    q = (rvalid_i === 1'b1) ? rdata_i : 'x;
  endtask : xfer
endmodule : rf_host_model
